//--- node_cfg_consts.svh
`ifndef NODE_CFG_CONSTS_SVH
`define NODE_CFG_CONSTS_SVH
// register offsets
`define FREQ_OFS 8'h51
`define LINK_OFS 8'h80
`define WDT_OFS 8'hd6
`define WDK_OFS 8'hd7
// frequency field
`define FREQ_RST 7'h19
`define FREQ_MIN 7'h05
`define FREQ_MAX 7'h64
`define FREQ_MSB 6
// link field positions
`define LNK_ERR 27
`define LNK_ISS 26
`define LNK_CRD 25
`define LNK_INIT 24
`define LNK_RXR 23
`define TGAP_MSB 21
`define TGAP_LSB 11
`define KGAP_MSB 10
`define GAP_RST 11'h001
// watchdog
`define WDT_RST 16'h03e8
`define WDK_MAGIC 32'h0d15ab1e
`define WDK_ENABLE 32'h00000000
// tick period in ms, oscillator cycles per MHz per ms
`define TICK_MS 1
`define KHZ_PER_MHZ 1000
// system reset hold, oscillator cycles
`define SYS_RST_HOLD 524288
`endif

//--- node_cfg_pkg.sv
package node_cfg_pkg;
	typedef logic [6:0] freq_t;     // whole MHz
	typedef logic [10:0] gap_t;     // link spacing
	typedef logic [15:0] wd_cnt_t;  // watchdog ticks
	typedef logic [16:0] pre_t;     // prescaler count
	typedef enum logic [2:0] {
		WD_OFF  = 3'b001,
		WD_RUN  = 3'b010,
		WD_HOLD = 3'b100
	} wd_state_t;
endpackage : node_cfg_pkg

//--- node_clock_link_watchdog_config.sv
// Summary of operation
// - keep 7-bit MHz field, reset 25
// - out-of-range frequency write ignored and NACKed
// - timings derive from programmed frequency
// - error flag sets on event, read clears
// - read-only issued and held credit flags
// - init clears credit, sends credit request
// - receiver reset pulse, self clearing
// - transition spacing field, reset 1
// - token spacing field, reset 1
// - watchdog counts in 1 ms ticks
// - watchdog counts only in active state
// - timeout write needs complement, else NACK
// - valid kick restarts countdown
// - counter readable high half, timeout 1000
// - expiry triggers a reset
// - zero enables, magic disables and resets, except during the reset hold
// - key resets to magic, watchdog off
// - expiry reset is a full system reset
//
// Implementation choice: strobed register access.
`include "node_cfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module node_clock_link_watchdog_config
	import node_cfg_pkg::*;
#(
	parameter int RST_HOLD_CYC = `SYS_RST_HOLD
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,
	output logic             ack_out,
	output logic             nack_out,
	input  wire logic        link_err_in,
	input  wire logic        credit_issued_in,
	input  wire logic        credit_rx_in,
	output logic             credit_request_token_out,
	output logic             rx_reset_out,
	output logic      [10:0] trans_gap_out,
	output logic      [10:0] token_gap_out,
	input  wire logic        active_power_state_in,
	output logic             tick_1khz_out,
	output logic      [6:0]  freq_mhz_out,
	output logic             system_reset_out
);
	// decoded accesses
	logic wr_freq;
	logic wr_link;
	logic wr_wdt;
	logic wr_wdk;
	logic rd_link;
	logic freq_ok;   // written MHz within range
	logic pair_ok;   // timeout paired with complement
	assign wr_freq = wr_in && addr_in == `FREQ_OFS;
	assign wr_link = wr_in && addr_in == `LINK_OFS;
	assign wr_wdt  = wr_in && addr_in == `WDT_OFS;
	assign wr_wdk  = wr_in && addr_in == `WDK_OFS;
	assign rd_link = rd_in && addr_in == `LINK_OFS;
	assign freq_ok = wdata_in[`FREQ_MSB:0] >= `FREQ_MIN
		&& wdata_in[`FREQ_MSB:0] <= `FREQ_MAX
		&& wdata_in[31:7] == 25'h0000000;
	assign pair_ok = wdata_in[31:16] == ~wdata_in[15:0];

	// prescaler terminal count for one ms
	function automatic pre_t tick_limit(input freq_t mhz);
		logic [23:0] prod;
		prod = 24'(mhz) * 24'(`KHZ_PER_MHZ * `TICK_MS);
		return pre_t'(prod - 24'h000001);
	endfunction : tick_limit

	// state registers
	freq_t     freq_q;      // oscillator MHz
	logic      err_q;       // link error flag
	logic      crd_q;       // transmit credit held
	logic      creq_q;      // credit request pulse
	logic      rxr_q;       // receiver reset pulse
	gap_t      tgap_q;      // transition spacing
	gap_t      kgap_q;      // token spacing
	wd_cnt_t   tmo_q;       // programmed timeout
	wd_cnt_t   cnt_q;       // running countdown
	logic [31:0] key_q;     // disable key
	wd_state_t wd_q;        // watchdog state
	pre_t      pre_q;       // prescaler count
	logic      tick_q;      // 1 kHz tick pulse
	logic [19:0] hold_q;    // reset hold count
	logic      ack_q;       // accepted write answer
	logic      nack_q;      // refused write answer
	logic [31:0] rdata_q;   // registered read data

	// frequency field, range checked
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			freq_q <= `FREQ_RST;
		end else if (ce_in && wr_freq && freq_ok) begin
			freq_q <= wdata_in[`FREQ_MSB:0];
		end
	end

	// write answer: ack or nack one cycle later
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ack_q  <= 1'b0;
			nack_q <= 1'b0;
		end else if (ce_in) begin
			// unmapped write is nacked
			ack_q <= (wr_freq && freq_ok) || wr_link
				|| (wr_wdt && pair_ok) || wr_wdk;
			nack_q <= wr_in && !((wr_freq && freq_ok)
				|| wr_link || (wr_wdt && pair_ok)
				|| wr_wdk);
		end
	end

	// link error flag: set beats read clear
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			err_q <= 1'b0;
		end else if (ce_in) begin
			if (link_err_in) begin
				err_q <= 1'b1;
			end else if (rd_link) begin
				err_q <= 1'b0;
			end
		end
	end

	// transmit credit: arriving credit beats init clear
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			crd_q <= 1'b0;
		end else if (ce_in) begin
			if (credit_rx_in) begin
				crd_q <= 1'b1;
			end else if (wr_link && wdata_in[`LNK_INIT]) begin
				crd_q <= 1'b0;
			end
		end
	end

	// self-clearing link command pulses
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			creq_q <= 1'b0;
			rxr_q  <= 1'b0;
		end else if (ce_in) begin
			creq_q <= wr_link && wdata_in[`LNK_INIT];
			rxr_q  <= wr_link && wdata_in[`LNK_RXR];
		end
	end

	// spacing fields
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			tgap_q <= `GAP_RST;
			kgap_q <= `GAP_RST;
		end else if (ce_in && wr_link) begin
			tgap_q <= wdata_in[`TGAP_MSB:`TGAP_LSB];
			kgap_q <= wdata_in[`KGAP_MSB:0];
		end
	end

	// 1 kHz prescaler from oscillator clock
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			pre_q  <= 17'h00000;
			tick_q <= 1'b0;
		end else if (ce_in) begin
			// restart on frequency change
			if (wr_freq && freq_ok) begin
				pre_q  <= 17'h00000;
				tick_q <= 1'b0;
			end else if (pre_q >= tick_limit(freq_q)) begin
				pre_q  <= 17'h00000;
				tick_q <= 1'b1;
			end else begin
				pre_q  <= pre_q + 17'h00001;
				tick_q <= 1'b0;
			end
		end
	end

	// timeout field, accepted only when paired
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			tmo_q <= `WDT_RST;
		end else if (ce_in && wr_wdt && pair_ok) begin
			tmo_q <= wdata_in[15:0];
		end
	end

	// disable key register
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			key_q <= `WDK_MAGIC;
		end else if (ce_in && wr_wdk) begin
			key_q <= wdata_in;
		end
	end

	// watchdog state and countdown
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wd_q   <= WD_OFF;
			cnt_q  <= 16'h0000;
			hold_q <= 20'h00000;
		end else if (ce_in) begin
			unique case (wd_q)
				WD_OFF: begin
					// zero write arms the countdown
					if (wr_wdk && wdata_in == `WDK_ENABLE) begin
						wd_q  <= WD_RUN;
						cnt_q <= tmo_q;
					end
				end
				WD_RUN: begin
					if (wr_wdk && wdata_in == `WDK_MAGIC) begin
						wd_q  <= WD_OFF;
						cnt_q <= 16'h0000;
					end else if (wr_wdt && pair_ok) begin
						cnt_q <= wdata_in[15:0];
					end else if (tick_q && active_power_state_in) begin
						// counts ms ticks while active only
						if (cnt_q <= 16'h0001) begin
							wd_q   <= WD_HOLD;
							cnt_q  <= 16'h0000;
							hold_q <= 20'h00000;
						end else begin
							cnt_q <= cnt_q - 16'h0001;
						end
					end
				end
				WD_HOLD: begin
					// stretch the system reset
					if (hold_q >= 20'(RST_HOLD_CYC - 1)) begin
						wd_q  <= WD_RUN;
						cnt_q <= tmo_q;
					end else begin
						hold_q <= hold_q + 20'h00001;
					end
				end
			endcase
		end
	end

	// read data, one cycle after strobe
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rdata_q <= 32'h00000000;
		end else if (ce_in) begin
			rdata_q <= 32'h00000000;
			if (rd_in) begin
				unique case (addr_in)
					`FREQ_OFS: rdata_q <= {25'h0000000, freq_q};
					`LINK_OFS: rdata_q <= {4'h0, err_q,
						credit_issued_in, crd_q, 3'h0,
						tgap_q, kgap_q};
					`WDT_OFS: rdata_q <= {cnt_q, tmo_q};
					`WDK_OFS: rdata_q <= key_q;
					default: rdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	// outputs
	assign rdata_out     = rdata_q;
	assign ack_out       = ack_q;
	assign nack_out      = nack_q;
	assign credit_request_token_out = creq_q;
	assign rx_reset_out  = rxr_q;
	assign trans_gap_out = tgap_q;
	assign token_gap_out = kgap_q;
	assign tick_1khz_out = tick_q;
	assign freq_mhz_out  = freq_q;
	assign system_reset_out = wd_q == WD_HOLD;

	// checker helper: cycles the system reset has stood so far
	logic [19:0] rst_len_q; // reset length seen by the checks
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rst_len_q <= 20'h00000;
		end else if (ce_in) begin
			// restarts whenever the system reset is released
			rst_len_q <= system_reset_out ? rst_len_q + 20'h00001 : 20'h00000;
		end
	end

	// checks
	sequence s_bad_freq;
		ce_in && wr_freq && !freq_ok;
	endsequence
	sequence s_kick;
		ce_in && wr_wdt && pair_ok && wd_q == WD_RUN;
	endsequence
	sequence s_tick_run;
		ce_in && wd_q == WD_RUN && tick_q && active_power_state_in && !wr_in;
	endsequence

	a_freq_range: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_bad_freq |=> $stable(freq_q) && nack_out && !ack_out)
		else $error("bad frequency write not refused");
	a_freq_store: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && wr_freq && freq_ok |=> freq_q == $past(wdata_in[6:0]) && ack_out)
		else $error("frequency write not stored");
	a_err_sticky: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && link_err_in |=> err_q)
		else $error("error flag not set");
	a_err_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && rd_link && !link_err_in |=> !err_q)
		else $error("error flag not cleared by read");
	a_err_read: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && rd_link |=> rdata_out[`LNK_ERR] == $past(err_q))
		else $error("error flag not shown on read");
	// link credit, receiver reset, watchdog and tick checks
	a_credit_show: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && rd_link |=> rdata_out[`LNK_CRD] == $past(crd_q)
		&& rdata_out[`LNK_ISS] == $past(credit_issued_in))
		else $error("credit flags not shown on read");
	a_credit_arrive: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && credit_rx_in |=> crd_q)
		else $error("arriving credit not held");
	a_credit_init: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && wr_link && wdata_in[24] && !credit_rx_in
		|=> credit_request_token_out && !crd_q)
		else $error("credit init failed");
	a_rx_reset: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && wr_link && wdata_in[23] |=> rx_reset_out)
		else $error("receiver reset pulse missing");
	a_rx_self_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && rx_reset_out && !(wr_link && wdata_in[`LNK_RXR]) |=> !rx_reset_out)
		else $error("receiver reset did not clear itself");
	a_creq_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && credit_request_token_out && !(wr_link && wdata_in[`LNK_INIT])
		|=> !credit_request_token_out)
		else $error("credit request did not clear itself");
	a_wdt_pair: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && wr_wdt && !pair_ok |=> nack_out && $stable(tmo_q))
		else $error("unpaired timeout accepted");
	a_wdt_kick: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_kick |=> cnt_q == $past(wdata_in[15:0]))
		else $error("kick did not restart countdown");
	a_wdt_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		wd_q == WD_RUN && !active_power_state_in && !wr_in |=> $stable(cnt_q))
		else $error("watchdog counted while not active");
	a_wdt_magic: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && wr_wdk && wdata_in == 32'h0d15ab1e && wd_q != WD_HOLD
		|=> wd_q == WD_OFF && cnt_q == 16'h0000)
		else $error("magic value did not disable");
	a_wdt_expire: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && wd_q == WD_RUN && tick_q && active_power_state_in
		&& cnt_q == 16'h0001 && !wr_in |=> system_reset_out)
		else $error("expiry did not raise reset");
	a_wdt_count: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_tick_run ##0 (cnt_q > 16'h0001) |=> cnt_q == $past(cnt_q) - 16'h0001)
		else $error("watchdog did not count down a tick");
	a_tick_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && tick_1khz_out |=> !tick_1khz_out)
		else $error("tick longer than one cycle");
	// register bus answers
	a_write_answer: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && wr_in |=> ack_out ^ nack_out)
		else $error("write not answered by exactly one of ack and nack");
	// system reset length
	a_rst_length: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && system_reset_out && rst_len_q == 20'(RST_HOLD_CYC - 1) |=> !system_reset_out)
		else $error("system reset held too long");
	a_rst_stays: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && system_reset_out && rst_len_q < 20'(RST_HOLD_CYC - 1) |=> system_reset_out)
		else $error("system reset released early");
endmodule : node_clock_link_watchdog_config
`default_nettype wire

//--- link_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
// remote link end: answers a credit request with credits after a set delay
module link_remote_model (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_in,
	input  wire logic       credit_request_token_in, // request token from the device
	input  wire logic [3:0] dly_in,                  // reply delay in cycles, 1 is prompt
	input  wire logic       err_cmd_in,              // bench command: corrupt a token
	output logic            credit_rx_out,           // credits arrive, one cycle
	output logic            link_err_out             // receiver saw an illegal token
);
	logic [3:0] dly_q; // reply countdown, zero when idle
	// answer each request token with credits
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			dly_q         <= 4'h0;
			credit_rx_out <= 1'b0;
		end else begin
			credit_rx_out <= (dly_q == 4'h1);
			if (credit_request_token_in) begin
				dly_q <= dly_in;
			end else if (dly_q != 4'h0) begin
				dly_q <= dly_q - 4'h1;
			end
		end
	end
	// bad token only when the bench asks for one
	always_ff @(posedge clk_sys_in) begin
		link_err_out <= !rst_in && err_cmd_in;
	end
endmodule : link_remote_model
`default_nettype wire

//--- node_clock_link_watchdog_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module node_clock_link_watchdog_config_tb;
	logic        clk_sys_in, rst_in, ce_in, wr_in, rd_in, ack_out, nack_out;
	logic [7:0]  addr_in;
	logic [31:0] wdata_in, rdata_out;
	logic        link_err_in, credit_issued_in, credit_rx_in, err_cmd, act;
	logic        credit_request_token_out, rx_reset_out, tick_1khz_out, system_reset_out;
	logic [10:0] trans_gap_out, token_gap_out;
	logic [6:0]  freq_mhz_out;
	logic [3:0]  dly;
	int          miscompares, tests_run, n, i;
	logic [6:0]  fv [4] = '{7'h04, 7'h65, 7'h05, 7'h64}; // below, above, both ends
	// clock, 100 MHz
	always #5 clk_sys_in = !clk_sys_in;
	node_clock_link_watchdog_config #(.RST_HOLD_CYC(8)) dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .ack_out(ack_out), .nack_out(nack_out), .link_err_in(link_err_in),
		.credit_issued_in(credit_issued_in), .credit_rx_in(credit_rx_in),
		.credit_request_token_out(credit_request_token_out), .rx_reset_out(rx_reset_out),
		.trans_gap_out(trans_gap_out), .token_gap_out(token_gap_out), .active_power_state_in(act),
		.tick_1khz_out(tick_1khz_out), .freq_mhz_out(freq_mhz_out), .system_reset_out(system_reset_out));
	link_remote_model peer_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.credit_request_token_in(credit_request_token_out), .dly_in(dly), .err_cmd_in(err_cmd),
		.credit_rx_out(credit_rx_in), .link_err_out(link_err_in));
	// verdict and end of run
	task results;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	// compare one value
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// bus write, answer checked in the cycle after
	task wrchk(input logic [7:0] a, input logic [31:0] d, input logic ok);
		@(posedge clk_sys_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		#1 chk({30'h0, ack_out, nack_out}, ok ? 32'h2 : 32'h1);
	endtask : wrchk
	// bus read, data checked in the cycle after
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 chk(rdata_out, exp);
	endtask : rdchk
	// cycles up to the next tick, bounded
	task wait_tick;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			#1 n++;
		end while (!tick_1khz_out && n < 10000);
		if (n >= 10000) begin
			chk(32'h0, 32'h1);
			results;
		end
	endtask : wait_tick
	// main sequence
	initial begin
		clk_sys_in = 0; rst_in = 1; ce_in = 1; addr_in = 0; wdata_in = 0; wr_in = 0; rd_in = 0;
		credit_issued_in = 0; err_cmd = 0; act = 0; dly = 4'h8; miscompares = 0; tests_run = 0;
		repeat (10) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		rdchk(8'h51, 32'h00000019);
		rdchk(8'h80, 32'h00000801);
		rdchk(8'hd6, 32'h000003e8);
		rdchk(8'hd7, 32'h0d15ab1e);
		for (i = 0; i < 4; i++) wrchk(8'h51, {25'h0, fv[i]}, i > 1);
		rdchk(8'h51, 32'h00000064);
		chk(freq_mhz_out, 32'h64);
		wrchk(8'h60, 32'h1, 1'b0);
		rdchk(8'h60, 32'h0);
		// link: credit request, slow reply, spacing fields
		@(posedge clk_sys_in);
		credit_issued_in <= 1'b1;
		wrchk(8'h80, 32'h01003005, 1'b1);
		chk(credit_request_token_out, 1);
		chk({trans_gap_out, token_gap_out}, 32'h3005);
		rdchk(8'h80, 32'h04003005);
		repeat (12) @(posedge clk_sys_in);
		rdchk(8'h80, 32'h06003005);
		@(posedge clk_sys_in);
		err_cmd <= 1'b1;
		@(posedge clk_sys_in);
		err_cmd <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		rdchk(8'h80, 32'h0e003005);
		rdchk(8'h80, 32'h06003005);
		wrchk(8'h80, 32'h00803005, 1'b1);
		chk(rx_reset_out, 1);
		@(posedge clk_sys_in);
		#1 chk(rx_reset_out, 0);
		// watchdog at 5 MHz: tick every 5000 cycles
		wrchk(8'h51, 32'h5, 1'b1);
		@(posedge clk_sys_in);
		act <= 1'b1;
		wait_tick;
		wait_tick;
		chk(n, 5000);
		wrchk(8'hd6, 32'h00000003, 1'b0);
		wrchk(8'hd6, 32'hfffc0003, 1'b1);
		wrchk(8'hd7, 32'h0, 1'b1);
		i = 0;
		repeat (3) begin
			wait_tick;
			i++;
			chk(system_reset_out, 0);
		end
		@(posedge clk_sys_in);
		#1 chk(system_reset_out, 1);
		n = 0;
		while (system_reset_out && n < 100) begin
			@(posedge clk_sys_in);
			#1 n++;
		end
		if (n >= 100) begin
			chk(32'h0, 32'h1);
			results;
		end
		chk(n, 8);
		@(posedge clk_sys_in);
		act <= 1'b0;
		rdchk(8'hd6, 32'h00030003);
		repeat (6000) @(posedge clk_sys_in);
		rdchk(8'hd6, 32'h00030003);
		@(posedge clk_sys_in);
		act <= 1'b1;
		wait_tick;
		rdchk(8'hd6, 32'h00020003);
		wrchk(8'hd6, 32'hfffc0003, 1'b1);
		rdchk(8'hd6, 32'h00030003);
		wrchk(8'hd7, 32'h0d15ab1e, 1'b1);
		rdchk(8'hd6, 32'h00000003);
		repeat (16000) @(posedge clk_sys_in);
		rdchk(8'hd6, 32'h00000003);
		chk(system_reset_out, 0);
		// usb-capable oscillator setting, then a write while the clock enable is low
		wrchk(8'h51, 32'h0000000c, 1'b1);
		chk(freq_mhz_out, 32'h0c);
		@(posedge clk_sys_in);
		ce_in    <= 1'b0;
		addr_in  <= 8'h51;
		wdata_in <= 32'h00000030;
		wr_in    <= 1'b1;
		@(posedge clk_sys_in);
		ce_in <= 1'b1;
		wr_in <= 1'b0;
		#1 chk({30'h0, ack_out, nack_out}, 32'h0);
		rdchk(8'h51, 32'h0000000c);
		results;
	end
endmodule : node_clock_link_watchdog_config_tb
`default_nettype wire
